// File: design/sarc_regs.svh
// Behaviour
// - Control settles, outputs update on rising edge
// - Start low at edge resets synchronously
// - Reset gives msb low, others high, done high
// - First edge loads msb, clears next bit
// - Each edge with echo buffer room fills low bit, clears next
// - Filling lsb drops done, then freezes
// - Width is 8 or 12 stages
// - Echo output repeats each captured decision two edges later while echo_ready is high and no start intervenes
// - Echo and enable are optional per variant
// - High enable forces msb high, holds rest
// - Held device ignores data until enable drops
// - True and inverted msb copies provided
// - Internal phases never overlap
`ifndef SARC_REGS_SVH
`define SARC_REGS_SVH
// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define SARC_WIDTH_NARROW 8
`define SARC_WIDTH_WIDE   12
`define SARC_DONE_RESET   1'h1
`define SARC_ECHO_RESET   1'h0
`define SARC_BUF_DEPTH    2
`endif

// File: design/sarc_pkg.sv
package sarc_pkg;
   // Conversion phases
   typedef enum logic [1:0] {SARC_IDLE, SARC_WALK, SARC_DONE} sarc_phase_e;
endpackage

// File: design/sarc_echo_buf.sv
`timescale 1ns/1ps
`include "sarc_regs.svh"
// ----------------------------------------
// Two-entry buffer on the echo data path
// ----------------------------------------
module sarc_echo_buf #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;   // Entries
      logic              wp;    // Write index
      logic              rp;    // Read index
      logic [1:0]        cnt;   // Fill level
   } sarc_buf_s;
   sarc_buf_s s_q;
   sarc_buf_s s_d;
   logic      push;
   logic      pop;
   // Handshake terms
   assign in_ready  = (s_q.cnt != 2'h2);
   assign out_valid = (s_q.cnt != 2'h0);
   assign out_data  = s_q.mem[s_q.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   // Next state
   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp          = ~s_q.wp;
      end
      if (pop)
         s_d.rp = ~s_q.rp;
      s_d.cnt = s_q.cnt + {1'h0, push} - {1'h0, pop};
   end
   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule

// File: design/sarc_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// Two-flop synchroniser for pin inputs
// ----------------------------------------
module sarc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] din,
   output logic [W-1:0]      dout
);
   typedef struct packed {
      logic [W-1:0] m;   // First stage
      logic [W-1:0] s;   // Second stage
   } sarc_sync_s;
   sarc_sync_s s_q;
   sarc_sync_s s_d;
   // Shift
   always_comb
   begin
      s_d   = s_q;
      s_d.m = din;
      s_d.s = s_q.m;
   end
   // Register
   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end
   assign dout = s_q.s;
endmodule

// File: design/sarc_register.sv
`timescale 1ns/1ps
`include "sarc_regs.svh"
// ----------------------------------------
// Successive-approximation control register
// ----------------------------------------
module sarc_register #(
   parameter int  WIDTH    = `SARC_WIDTH_NARROW,  // 8 or 12 stages
   parameter bit  HAS_ECHO = 1'b1,                 // Echo output fitted
   parameter bit  HAS_EN   = 1'b1                  // Cascade enable fitted
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             serial_in,
   input  wire logic             start_n,
   input  wire logic             enable_n,
   output logic [WIDTH-1:0]      q,
   output logic                  msb_out,
   output logic                  msb_out_n,
   output logic                  lsb_out,
   output logic                  done_n,
   output logic                  serial_echo,
   output logic                  echo_valid,
   input  wire logic             echo_ready
);
   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // Only the two register lengths are built
   if (WIDTH != `SARC_WIDTH_NARROW && WIDTH != `SARC_WIDTH_WIDE)
   begin : g_bad_width
      $error("WIDTH must be 8 or 12");
   end
   localparam int SW = $clog2(WIDTH + 1);   // Width of the step counter

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [2:0] pins_s;   // Synchronised {enable_n, start_n, serial_in}
   sarc_sync #(.W(3)) i_sarc_sync (
      .clk  (clk),
      .din  ({enable_n, start_n, serial_in}),
      .dout (pins_s)
   );
   logic dat;   // Decision bit
   logic st_n;  // Start, active low
   logic en_n;  // Enable, tied low if absent
   assign dat  = pins_s[0];
   assign st_n = pins_s[1];
   assign en_n = HAS_EN ? pins_s[2] : 1'b0;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0]    reg_bits;  // Stored result bits
      logic [WIDTH-1:0]    ptr;       // One-hot bit currently held low
      logic                done_n;    // Conversion complete, active low
      sarc_pkg::sarc_phase_e phase;   // Conversion phase
      logic                msb_out;   // Registered msb pin
      logic                msb_n;     // Registered inverted msb pin
      logic                lsb_out;   // Registered lsb pin
      logic [WIDTH-1:0]    q;         // Registered outputs
      logic                echo;      // Echo pin
      logic                echo_vld;  // Echo valid pin
      logic [SW-1:0]       steps;     // Decisions taken since start
   } sarc_state_s;
   sarc_state_s s_q;
   sarc_state_s s_d;

   // Echo buffer wiring
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_data;
   logic walk_step;   // A decision bit is being captured
   logic out_take;    // Echo stage empty or its word taken

   // ----------------------------------------
   // Echo buffer: decisions queue toward the echo pin
   // ----------------------------------------
   sarc_echo_buf #(.W(1)) i_sarc_echo_buf (
      .clk       (clk),
      .rst       (rst || !st_n),
      .in_valid  (walk_step && HAS_ECHO),
      .in_ready  (buf_in_ready),
      .in_data   (dat),
      .out_valid (buf_out_valid),
      .out_ready (out_take),
      .out_data  (buf_out_data)
   );

   // Step only while enabled and, when echo is fitted, buffer has room
   assign walk_step = (s_q.phase == sarc_pkg::SARC_WALK) && !en_n
                      && (!HAS_ECHO || buf_in_ready);
   // Echo stage accepts a word when empty or when the pins take its word
   assign out_take  = !s_q.echo_vld || echo_ready;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      logic [WIDTH-1:0] nb;
      logic [WIDTH-1:0] np;
      nb  = s_q.reg_bits;
      np  = s_q.ptr;
      s_d = s_q;
      if (!st_n)
      begin
         // Synchronous start: msb low, others high
         nb       = {1'b0, {(WIDTH-1){1'b1}}};
         np       = {1'b1, {(WIDTH-1){1'b0}}};
         s_d.done_n = `SARC_DONE_RESET;
         s_d.phase  = sarc_pkg::SARC_WALK;
         s_d.steps  = '0;
      end
      else if (walk_step)
      begin
         // Store decision into the low bit, clear the next one
         for (int i = 0; i < WIDTH; i++)
         begin
            if (s_q.ptr[i])
               nb[i] = dat;
            if (i > 0 && s_q.ptr[i])
               nb[i-1] = 1'b0;
         end
         np = s_q.ptr >> 1;
         s_d.steps = s_q.steps + SW'(1);
         if (s_q.ptr[0])
         begin
            s_d.done_n = 1'b0;
            s_d.phase  = sarc_pkg::SARC_DONE;
         end
      end
      s_d.reg_bits = nb;
      s_d.ptr      = np;
      // Output flops; enable forces msb high, stored bit kept
      s_d.q          = nb;
      s_d.q[WIDTH-1] = nb[WIDTH-1] | en_n;
      s_d.msb_out    = nb[WIDTH-1] | en_n;
      s_d.msb_n      = ~(nb[WIDTH-1] | en_n);
      s_d.lsb_out    = nb[0];
      // Echo stage refills only when empty or when its word is taken,
      // so a stalled consumer keeps seeing the same bit
      if (!st_n)
      begin
         // A new conversion drops any word left from the last one
         s_d.echo_vld = 1'b0;
      end
      else if (out_take)
      begin
         s_d.echo_vld = HAS_ECHO && buf_out_valid;
         if (HAS_ECHO && buf_out_valid)
            s_d.echo = buf_out_data;
      end
   end

   // ----------------------------------------
   // State register, all outputs on rising edge
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q          <= '0;
         s_q.reg_bits <= {1'b0, {(WIDTH-1){1'b1}}};
         s_q.q        <= {1'b0, {(WIDTH-1){1'b1}}};
         s_q.lsb_out  <= 1'b1;
         s_q.msb_n    <= 1'b1;
         s_q.done_n   <= `SARC_DONE_RESET;
         s_q.phase    <= sarc_pkg::SARC_IDLE;
      end
      else
         s_q <= s_d;
   end

   // Outputs straight from flops
   assign q           = s_q.q;
   assign msb_out     = s_q.msb_out;
   assign msb_out_n   = s_q.msb_n;
   assign lsb_out     = s_q.lsb_out;
   assign done_n      = s_q.done_n;
   assign serial_echo = s_q.echo;
   assign echo_valid  = s_q.echo_vld;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_reset_pattern;
      @(posedge clk) disable iff (rst)
      !st_n |=> (s_q.reg_bits == {1'b0, {(WIDTH-1){1'b1}}}) && done_n;
   endproperty
   a_reset_pattern: assert property (p_reset_pattern)
      else $error("start did not reset pattern");

   property p_done_freeze;
      @(posedge clk) disable iff (rst)
      (!done_n && st_n) |=> $stable(s_q.reg_bits);
   endproperty
   a_done_freeze: assert property (p_done_freeze)
      else $error("register changed after done");

   property p_done_sticky;
      @(posedge clk) disable iff (rst)
      (!done_n && st_n) |=> !done_n;
   endproperty
   a_done_sticky: assert property (p_done_sticky)
      else $error("done rose without start");

   property p_step;
      @(posedge clk) disable iff (rst)
      (walk_step && st_n && !s_q.ptr[0]) |=> s_q.ptr == $past(s_q.ptr) >> 1;
   endproperty
   a_step: assert property (p_step)
      else $error("pointer did not walk");

   property p_hold;
      @(posedge clk) disable iff (rst)
      (st_n && en_n) |=> $stable(s_q.reg_bits) && $stable(s_q.done_n);
   endproperty
   a_hold: assert property (p_hold)
      else $error("held device changed");

   property p_force;
      @(posedge clk) disable iff (rst)
      en_n |=> msb_out;
   endproperty
   a_force: assert property (p_force)
      else $error("enable did not force msb");

   property p_inv;
      @(posedge clk) disable iff (rst)
      msb_out_n == !msb_out;
   endproperty
   a_inv: assert property (p_inv)
      else $error("msb copies disagree");

   sequence s_load;
      walk_step && st_n ##0 s_q.ptr[WIDTH-1];
   endsequence
   property p_first_load;
      @(posedge clk) disable iff (rst)
      s_load |=> s_q.reg_bits[WIDTH-1] == $past(dat) && !s_q.reg_bits[WIDTH-2];
   endproperty
   a_first_load: assert property (p_first_load)
      else $error("msb load wrong");

   // Final step: the lsb takes the decision and done falls with it
   sequence s_final;
      walk_step && st_n ##0 s_q.ptr[0];
   endsequence
   property p_last_step;
      @(posedge clk) disable iff (rst)
      s_final |=> !done_n && (s_q.reg_bits[0] == $past(dat))
                  && (s_q.phase == sarc_pkg::SARC_DONE);
   endproperty
   a_last_step: assert property (p_last_step)
      else $error("lsb step did not end conversion");

   // Done only after exactly WIDTH decisions since the last start
   property p_count;
      @(posedge clk) disable iff (rst)
      !done_n |-> (s_q.steps == SW'(WIDTH));
   endproperty
   a_count: assert property (p_count)
      else $error("done after wrong number of steps");

   // Before the first start nothing moves
   property p_idle_quiet;
      @(posedge clk) disable iff (rst)
      (s_q.phase == sarc_pkg::SARC_IDLE && st_n)
         |=> $stable(s_q.reg_bits) && (s_q.phase == sarc_pkg::SARC_IDLE);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("register moved without start");

   // Start outputs: low-order pins high, msb low unless forced
   property p_reset_out;
      @(posedge clk) disable iff (rst)
      !st_n |=> (q[WIDTH-2:0] == {(WIDTH-1){1'b1}}) && lsb_out
                && (msb_out == $past(en_n));
   endproperty
   a_reset_out: assert property (p_reset_out)
      else $error("start outputs wrong");

   // A full buffer stops the walk so no decision is lost
   property p_stall;
      @(posedge clk) disable iff (rst)
      (st_n && HAS_ECHO && !buf_in_ready) |=> $stable(s_q.reg_bits) && $stable(s_q.ptr);
   endproperty
   a_stall: assert property (p_stall)
      else $error("walk moved while buffer full");

   // A waiting echo word stays on the pins until taken
   property p_echo_hold;
      @(posedge clk) disable iff (rst)
      (echo_valid && !echo_ready && st_n) |=> echo_valid && $stable(serial_echo);
   endproperty
   a_echo_hold: assert property (p_echo_hold)
      else $error("echo word dropped while stalled");

   // A capture into an empty path reaches the echo pin two edges on
   sequence s_capture;
      walk_step && st_n && HAS_ECHO && !buf_out_valid;
   endsequence
   sequence s_pass;
      st_n && echo_ready;
   endsequence
   property p_echo_follow;
      @(posedge clk) disable iff (rst)
      s_capture ##1 s_pass |=> echo_valid && (serial_echo == $past(dat, 2));
   endproperty
   a_echo_follow: assert property (p_echo_follow)
      else $error("echo bit differs from captured bit");
endmodule

// File: bench/sarc_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// DAC and comparator loop stand-in
// ----------------------------------------
module sarc_partner #(
   parameter int WIDTH = 12
) (
   input  wire logic             clk,
   input  wire logic             start_n,
   input  wire logic [WIDTH-1:0] word,
   output logic                  serial_in
);
   int idx = WIDTH;  // Next decision to present
   initial serial_in = 1'b0;
   // Start restarts the decisions, msb first
   always @(posedge clk)
   begin
      if (!start_n)
      begin
         serial_in <= word[WIDTH-1];
         idx       <= 1;
      end
      else if (idx < WIDTH)
      begin
         serial_in <= word[WIDTH-1-idx];
         idx       <= idx + 1;
      end
      else
         // Past the word the line keeps changing
         serial_in <= ~serial_in;
   end
endmodule

// File: bench/tb_successive_approx_register.sv
`timescale 1ns/1ps
module tb_successive_approx_register;
   localparam int W = 12;
   localparam logic [W-1:0] RST_PAT = {1'b0, {(W-1){1'b1}}};
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         start_n = 1'b1;
   logic         enable_n = 1'b0;
   logic         echo_ready = 1'b1;
   logic         serial_in;
   logic [W-1:0] word = 12'h000;
   logic [W-1:0] q;
   logic         msb_out, msb_out_n, lsb_out, done_n, serial_echo, echo_valid;
   logic [W-1:0] echo_word = 12'h000;  // Echoed decisions, msb first
   int           echo_cnt = 0;
   int           mismatches = 0;
   int           tests_run = 0;
   int           cyc = 0;
   logic [W-1:0] words [4] = '{12'hA5C, 12'h000, 12'hFFF, 12'h5A3};

   always #50 clk = ~clk;
   // Collect echo words and cut a hang short
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (echo_valid === 1'b1 && echo_ready)
      begin
         echo_word <= {echo_word[W-2:0], serial_echo};
         echo_cnt  <= echo_cnt + 1;
      end
      if (cyc == 20000)
      begin
         mismatches++;
         summarize();
      end
   end

   sarc_register #(.WIDTH(W), .HAS_ECHO(1'b1), .HAS_EN(1'b1)) i_sarc_register (
      .clk(clk), .rst(rst), .serial_in(serial_in), .start_n(start_n),
      .enable_n(enable_n), .q(q), .msb_out(msb_out), .msb_out_n(msb_out_n),
      .lsb_out(lsb_out), .done_n(done_n), .serial_echo(serial_echo),
      .echo_valid(echo_valid), .echo_ready(echo_ready));
   sarc_partner #(.WIDTH(W)) i_sarc_partner (
      .clk(clk), .start_n(start_n), .word(word), .serial_in(serial_in));

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [W-1:0] exp, input logic [W-1:0] got);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Inputs change 1 ns after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Start held low across exactly one edge
   task automatic start_conv();
      start_n  = 1'b0;
      echo_cnt = 0;
      tick(1);
      start_n = 1'b1;
   endtask

   task automatic wait_done(input int lim);
      int n;
      n = 0;
      while (done_n !== 1'b0 && n < lim)
      begin
         tick(1);
         n++;
      end
      chk("done_n", 12'h000, {11'h000, done_n});
   endtask

   task automatic test_reset();
      chk("q", RST_PAT, q);
      chk("done_n", 12'h001, {11'h000, done_n});
      chk("msb_n", 12'h001, {11'h000, msb_out_n});
      chk("lsb", 12'h001, {11'h000, lsb_out});
      $display("test reset done");
   endtask

   task automatic test_convert(input logic [W-1:0] w);
      int n;
      word = w;
      start_conv();
      n = 0;
      while (q !== RST_PAT && n < 6)
      begin
         tick(1);
         n++;
      end
      chk("q start", RST_PAT, q);
      chk("done_n", 12'h001, {11'h000, done_n});
      wait_done(30);
      chk("q", w, q);
      chk("msb", {11'h000, w[W-1]}, {11'h000, msb_out});
      chk("msb_n", {11'h000, ~w[W-1]}, {11'h000, msb_out_n});
      chk("lsb", {11'h000, w[0]}, {11'h000, lsb_out});
      tick(3);
      chk("echo cnt", W[W-1:0], echo_cnt[W-1:0]);
      chk("echo", w, echo_word);
      tick(5);
      chk("q frozen", w, q);
      $display("test convert %h done", w);
   endtask

   task automatic test_stall();
      word = 12'h6C9;
      echo_ready = 1'b0;
      start_conv();
      tick(W + 8);
      chk("done_n stalled", 12'h001, {11'h000, done_n});
      // Three decisions fit: two buffer entries and the echo output stage
      chk("q stalled", {word[W-1:W-3], 1'b0, {(W-4){1'b1}}}, q);
      echo_ready = 1'b1;
      wait_done(40);
      tick(3);
      chk("echo cnt", W[W-1:0], echo_cnt[W-1:0]);
      chk("echo", q, echo_word);
      $display("test stall done");
   endtask

   // Short cycle: a new start once a chosen output goes low ends the conversion early, before done falls
   task automatic test_short();
      int n;
      word = 12'h3B7;
      start_conv();
      tick(2);
      n = 0;
      while (q[W-5] !== 1'b0 && n < 20)
      begin
         tick(1);
         n++;
      end
      chk("short top", {8'h00, word[W-1:W-4]}, {8'h00, q[W-1:W-4]});
      chk("short done_n", 12'h001, {11'h000, done_n});
      start_conv();
      tick(2);
      chk("short restart", RST_PAT, q);
      $display("test short done");
   endtask

   task automatic test_enable();
      enable_n = 1'b1;
      start_conv();
      tick(W + 6);
      chk("q held", {W{1'b1}}, q);
      chk("msb", 12'h001, {11'h000, msb_out});
      chk("msb_n", 12'h000, {11'h000, msb_out_n});
      chk("done_n", 12'h001, {11'h000, done_n});
      enable_n = 1'b0;
      wait_done(40);
      $display("test enable done");
   endtask

   initial
   begin
      tick(12);
      rst = 1'b0;
      tick(2);
      test_reset();
      foreach (words[i])
         test_convert(words[i]);
      test_stall();
      test_short();
      test_enable();
      summarize();
   end
endmodule
